// ---- logic/cpts_capture_unit.sv ----
// Notes on behaviour
// R01 - Four capture prescaler settings via mode field.
// R02 - Prescaler cleared when off or not capturing.
// R03 - Any reset clears every prescaler counter.
// R04 - Changing prescaler in capture keeps the count.
// R05 - Software should switch channel off before changing.
// R06 - Capture time base is a 16-bit timer.
// R07 - Timer clocks: system, quarter, oscillator, pin.
// R08 - Internal-clocked timer halts in sleep, resumes.
// R09 - Pin-clocked timer keeps capture alive in sleep.
// R10 - Timer choice codes 00, 01, 10; 11 reserved.
// R11 - First select register: bits 1-0, 4-3, 7-6.
// R12 - Second select register: bits 1-0, 3-2, upper zero.
// R13 - Each channel has 16-bit value, high and low.
// R14 - Capture copies timer count and sets flag.
`timescale 1ns/1ps
`default_nettype none
module cpts_capture_unit #(
  parameter int NCH = cpts_pkg::NUM_CHAN,
  parameter int W   = cpts_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  // Pins and power state
  input  wire logic [NCH-1:0] capturePin,
  input  wire logic           secOscPin,
  input  wire logic [2:0]     timerExtClkPin,
  input  wire logic           sleepMode,
  // Interrupt
  output var  logic           irq
);

  localparam int NT = cpts_pkg::NUM_TMR;

  // Software-visible register storage.
  logic [7:0]     ctrl_r [NCH];
  logic [W-1:0]   val_r [NCH];
  logic [7:0]     selA_r;
  logic [7:0]     selB_r;
  logic [11:0]    tmrCtl_r;
  logic [NCH-1:0] intStat_r;
  logic [NCH-1:0] intStat_nxt;
  logic [NCH-1:0] intMask_r;
  logic           respDone_r;
  logic [31:0]    prdata_r;
  logic           pslverr_r;
  logic [31:0]    readData;
  logic           addrHit;

  // Wiring between the timers, the channels and the bus decoder.
  logic [W-1:0]   tmrCount [NT];
  logic [NCH-1:0] capEvent;
  logic [W-1:0]   capData [NCH];
  logic [1:0]     chanSel [NCH];
  logic [W-1:0]   chanBase [NCH];
  logic [NCH-1:0] ctrlHit;
  logic [NCH-1:0] valLoHit;
  logic [NCH-1:0] valHiHit;
  logic [NT-1:0]  tmrCntHit;

  function automatic logic [7:0] regAddr(input logic [7:0] base,
                                         input logic [7:0] stride,
                                         input int         idx);
    logic [7:0] step;
    step    = 8'(idx);
    regAddr = 8'(base + 8'(stride * step));
  endfunction : regAddr

  // Reserved code 11 falls back to the first timer rather than a floating value.
  function automatic logic [W-1:0] pickTimer(input logic [1:0]   sel,
                                             input logic [W-1:0] t1,
                                             input logic [W-1:0] t3,
                                             input logic [W-1:0] t5);
    case (sel)
      cpts_pkg::TSEL_T3: pickTimer = t3;
      cpts_pkg::TSEL_T5: pickTimer = t5;
      default:           pickTimer = t1;
    endcase
  endfunction : pickTimer

  // Bus handshake: one wait state, so read data always comes from a flop.
  wire access = psel & penable;
  wire sample = access & ~respDone_r;
  assign pready  = access & respDone_r;
  assign pslverr = pready & pslverr_r;
  assign prdata  = prdata_r;
  wire wrEn = pready & pwrite;

  wire selAHit    = (paddr == cpts_pkg::ADDR_SEL_A);
  wire selBHit    = (paddr == cpts_pkg::ADDR_SEL_B);
  wire tmrCtlHit  = (paddr == cpts_pkg::ADDR_TMR_CTL);
  wire intStatHit = (paddr == cpts_pkg::ADDR_INT_STAT);
  wire intMaskHit = (paddr == cpts_pkg::ADDR_INT_MASK);

  // Write strobes, one per register; each can only fire while pready is high.
  wire           selAWr    = wrEn & selAHit;
  wire           selBWr    = wrEn & selBHit;
  wire           tmrCtlWr  = wrEn & tmrCtlHit;
  wire           intStatWr = wrEn & intStatHit;
  wire           intMaskWr = wrEn & intMaskHit;
  wire [NCH-1:0] ctrlWr    = {NCH{wrEn}} & ctrlHit;
  wire [NCH-1:0] valLoWr   = {NCH{wrEn}} & valLoHit;
  wire [NCH-1:0] valHiWr   = {NCH{wrEn}} & valHiHit;

  // Zero-extended read words; the upper lanes of every register read zero.
  wire [31:0]    selAWord    = {24'h00_0000, selA_r};
  wire [31:0]    selBWord    = {24'h00_0000, selB_r};
  wire [31:0]    tmrCtlWord  = {20'h0_0000, tmrCtl_r};
  wire [31:0]    intStatWord = {{(32-NCH){1'b0}}, intStat_r};
  wire [31:0]    intMaskWord = {{(32-NCH){1'b0}}, intMask_r};

  // Per-channel timer choice fields. [R11] [R12]
  assign chanSel[0] = selA_r[cpts_pkg::SEL_A_CH1_LSB +: 2];
  assign chanSel[1] = selA_r[cpts_pkg::SEL_A_CH2_LSB +: 2];
  assign chanSel[2] = selA_r[cpts_pkg::SEL_A_CH3_LSB +: 2];
  assign chanSel[3] = selB_r[cpts_pkg::SEL_B_CH4_LSB +: 2];
  assign chanSel[4] = selB_r[cpts_pkg::SEL_B_CH5_LSB +: 2];

  // Each timer keeps its own oscillator synchroniser: a few more flops, but the
  // timers stay independent and a timer left idle can be trimmed away.
  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_tmr
      assign tmrCntHit[gi] = (paddr == regAddr(cpts_pkg::ADDR_TMR_CNT0,
                                               cpts_pkg::TMR_STRIDE, gi));
      cpts_timebase #(
        .W (W)
      ) cpts_timebase_inst (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clkSrc    (tmrCtl_r[gi*cpts_pkg::TMR_FIELD_W + cpts_pkg::TMR_SRC_LSB +: 2]),
        .enable    (tmrCtl_r[gi*cpts_pkg::TMR_FIELD_W + cpts_pkg::TMR_EN_BIT]),
        .sleepMode (sleepMode),
        .soscPin   (secOscPin),
        .extClkPin (timerExtClkPin[gi]),
        .count     (tmrCount[gi])
      );
    end
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      assign ctrlHit[gi]  = (paddr == regAddr(cpts_pkg::ADDR_CTRL0,
                                              cpts_pkg::CTRL_STRIDE, gi));
      assign valLoHit[gi] = (paddr == regAddr(cpts_pkg::ADDR_VAL_LO0,
                                              cpts_pkg::VAL_STRIDE, gi));
      assign valHiHit[gi] = (paddr == regAddr(cpts_pkg::ADDR_VAL_HI0,
                                              cpts_pkg::VAL_STRIDE, gi));
      assign chanBase[gi] = pickTimer(chanSel[gi], tmrCount[0], tmrCount[1],
                                      tmrCount[2]); // [R10]
      // A channel sees only the timer that its choice field names.
      cpts_channel #(
        .W (W)
      ) cpts_channel_inst (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .mode       (ctrl_r[gi][3:0]),
        .timerCount (chanBase[gi]),
        .capPin     (capturePin[gi]),
        .capEvent   (capEvent[gi]),
        .capData    (capData[gi])
      );
    end
  endgenerate

  // Read mux; unmapped addresses read zero and raise pslverr.
  always_comb begin
    readData = 32'h0000_0000;
    addrHit  = 1'b0;

    for (int i = 0; i < NCH; i++) begin
      if (ctrlHit[i]) begin
        readData = {24'h00_0000, ctrl_r[i]};
        addrHit  = 1'b1;
      end

      if (valLoHit[i]) begin
        readData = {24'h00_0000, val_r[i][7:0]}; // [R13]
        addrHit  = 1'b1;
      end

      if (valHiHit[i]) begin
        readData = {24'h00_0000, val_r[i][15:8]}; // [R13]
        addrHit  = 1'b1;
      end
    end

    for (int k = 0; k < NT; k++) begin
      if (tmrCntHit[k]) begin
        readData = {16'h0000, tmrCount[k]};
        addrHit  = 1'b1;
      end
    end

    if (selAHit) begin
      readData = selAWord; // [R11]
      addrHit  = 1'b1;
    end

    if (selBHit) begin
      readData = selBWord; // [R12]
      addrHit  = 1'b1;
    end

    if (tmrCtlHit) begin
      readData = tmrCtlWord;
      addrHit  = 1'b1;
    end

    if (intStatHit) begin
      readData = intStatWord;
      addrHit  = 1'b1;
    end

    if (intMaskHit) begin
      readData = intMaskWord;
      addrHit  = 1'b1;
    end
  end

  // A capture in the same cycle as a write-one-to-clear keeps its flag set.
  wire [NCH-1:0] w1c = intStatWr ? pwdata[NCH-1:0] : '0;
  assign intStat_nxt = (intStat_r & ~w1c) | capEvent; // [R14]
  // Built from flops only, so the interrupt line cannot glitch during a bus cycle.
  wire [NCH-1:0] pending = intStat_r & intMask_r;
  assign irq = |pending;

  // Read data is captured at the first access edge, so it is steady while pready is high.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      respDone_r <= 1'b0;
      prdata_r   <= 32'h0000_0000;
      pslverr_r  <= 1'b0;
    end else begin
      respDone_r <= sample;

      if (sample) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : readData;
        pslverr_r <= ~addrHit;
      end
    end
  end

  // Unused select bits are dropped on write, so they always read back as zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      selA_r    <= cpts_pkg::SEL_A_RESET;
      selB_r    <= cpts_pkg::SEL_B_RESET;
      tmrCtl_r  <= cpts_pkg::TMR_CTL_RESET;
      intStat_r <= cpts_pkg::INT_RESET;
      intMask_r <= cpts_pkg::INT_RESET;
    end else begin
      intStat_r <= intStat_nxt;
      if (selAWr) begin
        selA_r <= pwdata[7:0] & cpts_pkg::SEL_A_MASK; // [R11]
      end

      if (selBWr) begin
        selB_r <= pwdata[7:0] & cpts_pkg::SEL_B_MASK; // [R12]
      end

      if (tmrCtlWr) begin
        tmrCtl_r <= pwdata[11:0] & cpts_pkg::TMR_CTL_MASK;
      end

      if (intMaskWr) begin
        intMask_r <= pwdata[NCH-1:0];
      end
    end
  end

  // Channel control and value storage; a capture beats a software write.
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!rst_n) begin
        ctrl_r[i] <= cpts_pkg::CTRL_RESET;
        val_r[i]  <= cpts_pkg::VAL_RESET;
      end else begin
        if (ctrlWr[i]) begin
          ctrl_r[i] <= pwdata[7:0];
        end

        if (capEvent[i]) begin
          val_r[i] <= capData[i]; // [R14]
        end else if (valLoWr[i]) begin
          val_r[i][7:0] <= pwdata[7:0]; // [R13]
        end else if (valHiWr[i]) begin
          val_r[i][15:8] <= pwdata[7:0]; // [R13]
        end
      end
    end
  end

endmodule : cpts_capture_unit
`default_nettype wire

// ---- logic/cpts_pkg.sv ----
`default_nettype none
package cpts_pkg;

  // Block dimensions.
  localparam int NUM_CHAN = 5;
  localparam int NUM_TMR  = 3;
  localparam int CNT_W    = 16;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL0    = 8'h00;
  localparam logic [7:0] CTRL_STRIDE   = 8'h04;
  localparam logic [7:0] ADDR_VAL_LO0  = 8'h20;
  localparam logic [7:0] ADDR_VAL_HI0  = 8'h24;
  localparam logic [7:0] VAL_STRIDE    = 8'h08;
  localparam logic [7:0] ADDR_SEL_A    = 8'h50;
  localparam logic [7:0] ADDR_SEL_B    = 8'h54;
  localparam logic [7:0] ADDR_TMR_CTL  = 8'h58;
  localparam logic [7:0] ADDR_TMR_CNT0 = 8'h5C;
  localparam logic [7:0] TMR_STRIDE    = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h68;
  localparam logic [7:0] ADDR_INT_MASK = 8'h6C;

  // Reset values and writable-bit masks.
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  SEL_A_RESET    = 8'h00;
  localparam logic [7:0]  SEL_B_RESET    = 8'h00;
  localparam logic [7:0]  SEL_A_MASK     = 8'hDB;
  localparam logic [7:0]  SEL_B_MASK     = 8'h0F;
  localparam logic [11:0] TMR_CTL_RESET  = 12'h000;
  localparam logic [11:0] TMR_CTL_MASK   = 12'h777;
  localparam logic [4:0]  INT_RESET      = 5'h00;
  localparam logic [15:0] VAL_RESET      = 16'h0000;

  // Field positions.
  localparam int SEL_A_CH1_LSB = 0;
  localparam int SEL_A_CH2_LSB = 3;
  localparam int SEL_A_CH3_LSB = 6;
  localparam int SEL_B_CH4_LSB = 0;
  localparam int SEL_B_CH5_LSB = 2;
  localparam int TMR_FIELD_W   = 4;
  localparam int TMR_SRC_LSB   = 0;
  localparam int TMR_EN_BIT    = 2;

  // Channel mode field encodings.
  localparam logic [3:0] MODE_OFF        = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [1:0] MODE_CAP_GROUP  = 2'h1;

  // Last prescaler count before a capture fires.
  localparam logic [3:0] PS_LAST_1  = 4'h0;
  localparam logic [3:0] PS_LAST_4  = 4'h3;
  localparam logic [3:0] PS_LAST_16 = 4'hF;

  // Timer choice encodings.
  localparam logic [1:0] TSEL_T1   = 2'h0;
  localparam logic [1:0] TSEL_T3   = 2'h1;
  localparam logic [1:0] TSEL_T5   = 2'h2;
  localparam logic [1:0] TSEL_RSVD = 2'h3;

  // Time-base clock sources.
  localparam logic [1:0] SRC_SYS    = 2'h0;
  localparam logic [1:0] SRC_INSTR  = 2'h1;
  localparam logic [1:0] SRC_SOSC   = 2'h2;
  localparam logic [1:0] SRC_EXTPIN = 2'h3;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  // A synchronised level moves only once the last two stages agree.
  function automatic logic filtNext(input logic s2, input logic s3, input logic filt);
    filtNext = (s2 == s3) ? s2 : filt;
  endfunction : filtNext

endpackage : cpts_pkg
`default_nettype wire

// ---- logic/cpts_timebase.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpts_timebase #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Configuration
  input  wire logic [1:0]   clkSrc,
  input  wire logic         enable,
  input  wire logic         sleepMode,
  // Raw clock pins
  input  wire logic         soscPin,
  input  wire logic         extClkPin,
  // Count
  output var  logic [W-1:0] count
);

  logic [2:0]   soscSync_r;
  logic [2:0]   extSync_r;
  logic         soscFilt_r;
  logic         extFilt_r;
  logic [1:0]   div_r;
  logic [W-1:0] count_r;
  wire          soscRise = soscSync_r[1] & soscSync_r[2] & ~soscFilt_r;
  wire          extRise  = extSync_r[1] & extSync_r[2] & ~extFilt_r;
  wire          instrTick = (div_r == cpts_pkg::INSTR_DIV_LAST);
  // Internal sources halt in sleep; pin sources keep running. [R08] [R09]
  wire          tick = (clkSrc == cpts_pkg::SRC_SYS)   ? ~sleepMode :
                       (clkSrc == cpts_pkg::SRC_INSTR) ? (~sleepMode & instrTick) :
                       (clkSrc == cpts_pkg::SRC_SOSC)  ? soscRise : extRise; // [R07]

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      soscSync_r <= 3'h0;
      extSync_r  <= 3'h0;
      soscFilt_r <= 1'b0;
      extFilt_r  <= 1'b0;
      div_r      <= 2'h0;
      count_r    <= '0;
    end else begin
      soscSync_r <= {soscSync_r[1:0], soscPin};
      extSync_r  <= {extSync_r[1:0], extClkPin};
      soscFilt_r <= cpts_pkg::filtNext(soscSync_r[1], soscSync_r[2], soscFilt_r);
      extFilt_r  <= cpts_pkg::filtNext(extSync_r[1], extSync_r[2], extFilt_r);
      // The divider freezes in sleep so the count resumes where it stopped. [R08]
      if (!sleepMode) begin
        div_r <= div_r + 2'h1;
      end
      if (enable && tick) begin
        count_r <= count_r + {{(W-1){1'b0}}, 1'b1}; // [R06]
      end
    end
  end

  assign count = count_r;

endmodule : cpts_timebase
`default_nettype wire

// ---- logic/cpts_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpts_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Configuration and time base
  input  wire logic [3:0]   mode,
  input  wire logic [W-1:0] timerCount,
  // Raw capture pin
  input  wire logic         capPin,
  // Capture result
  output var  logic         capEvent,
  output var  logic [W-1:0] capData
);

  logic [2:0]   pinSync_r;
  logic         pinFilt_r;
  logic [3:0]   psCount_r;
  logic         capEvent_r;
  logic [W-1:0] capData_r;

  wire       rise    = pinSync_r[1] & pinSync_r[2] & ~pinFilt_r;
  wire       fall    = ~pinSync_r[1] & ~pinSync_r[2] & pinFilt_r;
  wire       capMode = (mode[3:2] == cpts_pkg::MODE_CAP_GROUP);
  // Four prescaler settings: every falling, every rising, 4th and 16th rising. [R01]
  wire       hit     = capMode & ((mode == cpts_pkg::MODE_CAP_FALL) ? fall : rise);
  wire [3:0] psLast  = (mode == cpts_pkg::MODE_CAP_RISE4)  ? cpts_pkg::PS_LAST_4 :
                       (mode == cpts_pkg::MODE_CAP_RISE16) ? cpts_pkg::PS_LAST_16 :
                       cpts_pkg::PS_LAST_1; // [R01]
  // Using >= means a stale count after a setting change can fire early. [R04] [R05]
  wire       psFire  = hit & (psCount_r >= psLast);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinSync_r  <= 3'h0;
      pinFilt_r  <= 1'b0;
      psCount_r  <= 4'h0; // [R03]
      capEvent_r <= 1'b0;
      capData_r  <= '0;
    end else begin
      pinSync_r  <= {pinSync_r[1:0], capPin};
      pinFilt_r  <= cpts_pkg::filtNext(pinSync_r[1], pinSync_r[2], pinFilt_r);
      capEvent_r <= psFire; // [R14]
      if (!capMode) begin
        psCount_r <= 4'h0; // [R02]
      end else if (psFire) begin
        psCount_r <= 4'h0;
      end else if (hit) begin
        psCount_r <= psCount_r + 4'h1; // [R04]
      end
      if (psFire) begin
        capData_r <= timerCount; // [R14]
      end
    end
  end

  assign capEvent = capEvent_r;
  assign capData  = capData_r;

endmodule : cpts_channel
`default_nettype wire

// ---- verif/cpts_capture_unit_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpts_capture_unit_chk #(
  parameter int NCH = 5
) (
  // Clock and reset
  input wire logic           ref_clk,
  input wire logic           rst_n,
  // APB
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [7:0]     paddr,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // Pins and interrupt
  input wire logic [NCH-1:0] capturePin,
  input wire logic           irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // A flag may only rise shortly after a pin moved or after a register write.
  logic [NCH-1:0] pinLast_r;
  logic [3:0]     pinAge_r;
  always_ff @(posedge ref_clk) begin
    pinLast_r <= capturePin;
    if (!rst_n || capturePin != pinLast_r) pinAge_r <= 4'h0;
    else if (pinAge_r != 4'hF) pinAge_r <= pinAge_r + 4'h1;
  end

  sequence waitOne;
    !pready ##1 pready;
  endsequence
  sequence readOf(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence

  chk_one_wait: assert property ($rose(penable) && psel |-> waitOne)
    else $error("access did not end after one wait state");
  chk_ready_qual: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_hole_refused: assert property (pready && paddr >= 8'h70 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_sel_a_holes: assert property (readOf(cpts_pkg::ADDR_SEL_A) |-> (prdata & ~32'hDB) == 0)
    else $error("first select register shows unused bits");
  chk_sel_b_upper: assert property (readOf(cpts_pkg::ADDR_SEL_B) |-> (prdata & ~32'h0F) == 0)
    else $error("second select register shows upper bits");
  chk_value_byte: assert property (pready && !pwrite && paddr inside {[8'h20:8'h47]} |-> prdata[31:8] == 24'h0)
    else $error("value byte register wider than a byte");
  chk_flag_cause: assert property ($rose(irq) |-> pinAge_r <= 4'h8 || $past(pready && pwrite))
    else $error("interrupt rose without a cause");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !irq && !pready)
    else $error("outputs not quiet after reset");
endmodule : cpts_capture_unit_chk

bind cpts_capture_unit cpts_capture_unit_chk #(.NCH(NCH)) chk_inst (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .capturePin(capturePin),
  .irq(irq)
);
`default_nettype wire

// ---- verif/cpts_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpts_pin_model (
  // Clock
  input  wire logic       ref_clk,
  // Pins toward the capture unit
  output var  logic [4:0] capPins,
  output var  logic       soscClk,
  output var  logic [2:0] extClks
);
  // The oscillator runs free, unrelated in phase to ref_clk.
  initial begin
    capPins = 5'h00;
    extClks = 3'h0;
    soscClk = 1'b0;
    forever #107 soscClk = ~soscClk;
  end

  // Levels stay four cycles so the input filter always sees them.
  task automatic capPulse(input int ch);
    capPins[ch] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    capPins[ch] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : capPulse

  task automatic extTick(input int k);
    extClks[k] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    extClks[k] <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : extTick
endmodule : cpts_pin_model
`default_nettype wire

// ---- verif/cpts_capture_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpts_capture_unit_bench;
  logic        ref_clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  capturePin;
  logic        secOscPin;
  logic [2:0]  timerExtClkPin;
  logic        sleepMode;
  logic        irq;
  logic        lastErr;
  int          err_total;
  int          cmp_count;

  cpts_capture_unit cpts_capture_unit_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capturePin(capturePin),
    .secOscPin(secOscPin), .timerExtClkPin(timerExtClkPin),
    .sleepMode(sleepMode), .irq(irq));
  cpts_pin_model cpts_pin_model_inst (.ref_clk(ref_clk), .capPins(capturePin),
    .soscClk(secOscPin), .extClks(timerExtClkPin));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("compared %0d, mismatched %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 20) begin
      err_total++;
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask : wr

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    check(nm, q, exp);
  endtask : rdChk

  // Extra cycles cover the filter and the two-edge update.
  task automatic pulses(input int ch, input int n);
    repeat (n) cpts_pin_model_inst.capPulse(ch);
    repeat (8) @(posedge ref_clk);
  endtask : pulses

  task automatic testRegs;
    rdChk("selA", 8'h50, 32'h0);
    rdChk("selB", 8'h54, 32'h0);
    wr(8'h50, 32'hFF);
    wr(8'h54, 32'hFF);
    rdChk("selA", 8'h50, 32'hDB);
    rdChk("selB", 8'h54, 32'h0F);
    rdChk("hole", 8'hF0, 32'h0);
    check("holeErr", {31'h0, lastErr}, 32'h1);
    wr(8'h24, 32'h5A);
    rdChk("valHi", 8'h24, 32'h5A);
    wr(8'h50, 32'h0);
    wr(8'h54, 32'h0);
    $display("register test ends");
  endtask : testRegs

  task automatic testModes;
    logic [3:0]  md [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int          cnt [4] = '{1, 1, 4, 16};
    logic [31:0] v;
    logic [31:0] t;
    wr(8'h58, 32'h4);
    wr(8'h6C, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, {28'h0, md[i]});
      wr(8'h68, 32'h1F);
      pulses(0, cnt[i] - 1);
      rdChk("early", 8'h68, 32'h0);
      check("irqLow", {31'h0, irq}, 32'h0);
      pulses(0, 1);
      rdChk("flag", 8'h68, 32'h1);
      check("irqHigh", {31'h0, irq}, 32'h1);
    end
    apb(1'b0, 8'h20, 32'h0, v);
    apb(1'b0, 8'h24, 32'h0, t);
    v = {16'h0, t[7:0], v[7:0]};
    apb(1'b0, 8'h5C, 32'h0, t);
    check("capTime", {31'h0, t - v < 32'd64}, 32'h1);
    wr(8'h68, 32'h1);
    rdChk("cleared", 8'h68, 32'h0);
    check("irqCleared", {31'h0, irq}, 32'h0);
    wr(8'h6C, 32'h0);
    pulses(0, 16);
    rdChk("masked", 8'h68, 32'h1);
    check("irqMasked", {31'h0, irq}, 32'h0);
    wr(8'h68, 32'h1);
    $display("mode test ends");
  endtask : testModes

  task automatic testPrescale;
    wr(8'h00, 32'h7);
    wr(8'h68, 32'h1F);
    pulses(0, 5);
    wr(8'h00, 32'h6);
    pulses(0, 1);
    rdChk("early", 8'h68, 32'h1);
    wr(8'h00, 32'h7);
    wr(8'h68, 32'h1F);
    pulses(0, 5);
    wr(8'h00, 32'h8);
    pulses(0, 2);
    wr(8'h00, 32'h6);
    pulses(0, 3);
    rdChk("held", 8'h68, 32'h0);
    pulses(0, 1);
    rdChk("fourth", 8'h68, 32'h1);
    $display("prescale test ends");
  endtask : testPrescale

  task automatic testReset;
    wr(8'h00, 32'h6);
    pulses(0, 2);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rdChk("ctrl", 8'h00, 32'h0);
    wr(8'h58, 32'h4);
    wr(8'h00, 32'h6);
    pulses(0, 3);
    rdChk("none", 8'h68, 32'h0);
    pulses(0, 1);
    rdChk("fourth", 8'h68, 32'h1);
    $display("reset test ends");
  endtask : testReset

  task automatic testSelect;
    logic [31:0] a;
    logic [31:0] b;
    wr(8'h58, 32'h775);
    apb(1'b0, 8'h5C, 32'h0, a);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 8'h5C, 32'h0, b);
    check("quarter", b - a, 32'd11);
    repeat (7) cpts_pin_model_inst.extTick(1);
    repeat (3) cpts_pin_model_inst.extTick(2);
    repeat (4) @(posedge ref_clk);
    rdChk("t3", 8'h60, 32'd7);
    rdChk("t5", 8'h64, 32'd3);
    wr(8'h50, 32'h08);
    wr(8'h54, 32'h08);
    wr(8'h04, 32'h5);
    wr(8'h10, 32'h5);
    sleepMode <= 1'b1;
    apb(1'b0, 8'h5C, 32'h0, a);
    repeat (2) cpts_pin_model_inst.extTick(1);
    pulses(1, 1);
    pulses(4, 1);
    apb(1'b0, 8'h5C, 32'h0, b);
    check("asleep", b, a);
    rdChk("v2lo", 8'h28, 32'd9);
    rdChk("v2hi", 8'h2C, 32'h0);
    rdChk("v5lo", 8'h40, 32'd3);
    rdChk("v5hi", 8'h44, 32'h0);
    sleepMode <= 1'b0;
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 8'h5C, 32'h0, a);
    check("wake", {31'h0, (a - b) >= 32'd10 && (a - b) <= 32'd11}, 32'h1);
    wr(8'h58, 32'h776);
    sleepMode <= 1'b1;
    apb(1'b0, 8'h5C, 32'h0, a);
    repeat (100) @(posedge ref_clk);
    apb(1'b0, 8'h5C, 32'h0, b);
    check("sosc", {31'h0, (b - a) >= 32'd12 && (b - a) <= 32'd13}, 32'h1);
    $display("select test ends");
  endtask : testSelect

  initial begin
    rst_n     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    sleepMode = 1'b0;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    testRegs();
    testModes();
    testPrescale();
    testReset();
    testSelect();
    print_verdict();
  end
endmodule : cpts_capture_unit_bench
`default_nettype wire
